// ---- rtl/flash_cfg.svh ----
// constant definitions for the erase and identification command sequencer
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
// opcodes
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_MAKER_PART 8'h90
`define OP_IDENT_24 8'h9F
`define OP_UNIQUE_ID 8'h4B
`define OP_SECURE_ERASE 8'h44
// serial bit counts at which a frame stage completes, and the count at which it saturates
`define BITS_OPCODE 6'h08
`define BITS_ADDR 6'h20
`define BITS_UID_LEAD 6'h28
`define BITS_SAT 6'h3F
// address alignment masks
`define ALIGN_32K 24'hFF8000
`define ALIGN_64K 24'hFF0000
// security register address fields
`define SEC_HI_ZERO 8'h00
`define SEC_MID_ZERO 2'h0
`define SEC_SEL_0 4'h0
`define SEC_SEL_1 4'h1
// protection decode: 64KB blocks in the array
`define ARRAY_BLOCKS 8'h08
`define BP_NONE 3'h0
`define BP_ALL 3'h7
// durations in microseconds and the clock rate in MHz
`define CLK_MHZ 32'd125
`define T_ERASE_32K_US 32'd150000
`define T_ERASE_64K_US 32'd300000
`define T_CHIP_ERASE_US 32'd3000000
`define T_SECTOR_ERASE_US 32'd60000
`endif

// ---- rtl/flash_pkg.sv ----
// types shared by the erase and identification sequencer
package flash_pkg;
	// frame decoder states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CMD = 5'h02,
		ST_ADDR = 5'h04,
		ST_OUT = 5'h08,
		ST_SKIP = 5'h10
	} seq_state_t;
	// kind of self-timed erase handed to the array
	typedef enum logic [1:0] {
		ER_32K = 2'h0,
		ER_64K = 2'h1,
		ER_CHIP = 2'h2,
		ER_SECURE = 2'h3
	} erase_kind_t;
endpackage

// ---- rtl/erase_timer.sv ----
// self-timed erase cycle counter
module erase_timer #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// start request with its length in cycles
	input wire logic start,
	input wire logic [W-1:0] cycles,
	// status
	output logic busy_r,
	output logic done_r
);
	logic [W-1:0] left_r; // cycles remaining

	// elaboration check: the countdown needs at least two bits
	if (W < 2)
	begin : g_w_check
		$error("erase_timer: W too small");
	end

	// load on start, count down, drop busy at zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			left_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else if (start && !busy_r)
		begin
			left_r <= cycles;
			busy_r <= 1'b1;
			done_r <= 1'b0;
		end
		else if (busy_r)
		begin
			// a zero length still takes one cycle
			left_r <= (left_r > W'(1)) ? left_r - W'(1) : '0;
			busy_r <= left_r > W'(1);
			done_r <= left_r <= W'(1);
		end
		else
		begin
			done_r <= 1'b0;
		end
	end
endmodule // erase_timer

// ---- rtl/flash_cmd_seq.sv ----
// serial command sequencer for block/chip/secure erase and id reads
`include "flash_cfg.svh"
module flash_cmd_seq #(
	parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'h12, // arbitrary value
	parameter logic [7:0] MEM_TYPE = 8'h40, // arbitrary value
	parameter logic [7:0] CAPACITY = 8'h13, // arbitrary value
	parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978, // arbitrary
	parameter int unsigned ERASE_32K_CYC = `T_ERASE_32K_US * `CLK_MHZ,
	parameter int unsigned ERASE_64K_CYC = `T_ERASE_64K_US * `CLK_MHZ,
	parameter int unsigned CHIP_ERASE_CYC = `T_CHIP_ERASE_US * `CLK_MHZ,
	parameter int unsigned SECTOR_ERASE_CYC = `T_SECTOR_ERASE_US * `CLK_MHZ
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial link pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	output logic so_out_r,
	output logic so_oe_n_r,
	// device state the sequencer consults
	input wire logic write_latch,
	input wire logic other_cycle_busy,
	input wire logic [4:0] protect_bits,
	input wire logic protect_complement,
	input wire logic secure_area_lock_0,
	input wire logic secure_area_lock_1,
	// effects on the rest of the device
	output logic progress_flag_r,
	output logic write_latch_clr_r,
	output logic erase_go_r,
	output flash_pkg::erase_kind_t erase_kind_r,
	output logic [23:0] erase_base_r,
	output logic erase_done_r
);
	flash_pkg::seq_state_t state_r; // frame decoder state
	logic [2:0] cs_sync_r, sclk_sync_r; // [0],[1] synchroniser, [2] edge history
	logic [1:0] si_sync_r; // data synchroniser
	logic cs_fall, cs_rise, sclk_rise, sclk_fall; // link events
	logic [5:0] bit_cnt_r, cnt_nxt; // bits taken this frame, saturating
	logic [31:0] in_sr_r, in_nxt; // input shifter
	logic [7:0] opcode_r; // opcode of this frame, zero until taken
	logic [23:0] addr_r; // address of this frame
	logic [127:0] out_sr_r; // output shifter, msb first
	logic timer_busy; // erase cycle running
	logic busy; // any internal cycle running
	logic block_ok, chip_ok, secure_ok; // command acceptance terms
	logic go; // start an erase this cycle
	flash_pkg::erase_kind_t kind; // kind of erase to start
	logic [31:0] go_cycles; // its length
	logic [23:0] go_base; // its aligned base

	// elaboration check: all four erase lengths must be nonzero
	if (ERASE_32K_CYC == 0 || ERASE_64K_CYC == 0 || CHIP_ERASE_CYC == 0
		|| SECTOR_ERASE_CYC == 0)
	begin : g_len_check
		$error("flash_cmd_seq: erase lengths must be nonzero");
	end

	// two flops before any use; the third stage only feeds edge finding
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_sync_r <= 3'h7;
			sclk_sync_r <= 3'h0;
			si_sync_r <= 2'h0;
		end
		else
		begin
			cs_sync_r <= {cs_sync_r[1:0], cs_n};
			sclk_sync_r <= {sclk_sync_r[1:0], sclk};
			si_sync_r <= {si_sync_r[0], si};
		end
	end

	// edges seen on the synchronised pins; sclk counts only while selected
	assign cs_fall = cs_sync_r[2] && !cs_sync_r[1];
	assign cs_rise = !cs_sync_r[2] && cs_sync_r[1];
	assign sclk_rise = !cs_sync_r[1] && !sclk_sync_r[2] && sclk_sync_r[1];
	assign sclk_fall = !cs_sync_r[1] && sclk_sync_r[2] && !sclk_sync_r[1];
	assign in_nxt = {in_sr_r[30:0], si_sync_r[1]};
	assign cnt_nxt = (bit_cnt_r == `BITS_SAT) ? bit_cnt_r : bit_cnt_r + 6'h01;
	assign busy = timer_busy || other_cycle_busy;

	// block protection: bp3 picks the bottom, complement inverts the range
	function automatic logic blk_protected(input logic [23:0] a, input logic [4:0] bp,
		input logic cmp);
		logic [7:0] n;
		logic [7:0] blk;
		logic cov;
		n = (bp[2:0] == `BP_NONE) ? 8'h00 : (8'h01 << (bp[2:0] - 3'h1));
		if (n > `ARRAY_BLOCKS)
			n = `ARRAY_BLOCKS;
		blk = {5'h00, a[18:16]};
		cov = bp[3] ? (blk < n) : (blk >= `ARRAY_BLOCKS - n);
		return cov ^ cmp;
	endfunction

	// acceptance of each erase at the select rise
	always_comb
	begin
		block_ok = (bit_cnt_r == `BITS_ADDR)
			&& !blk_protected(addr_r, protect_bits, protect_complement);
		chip_ok = (bit_cnt_r == `BITS_OPCODE)
			&& ((protect_bits[2:0] == `BP_NONE && !protect_complement)
			|| (protect_bits[2:0] == `BP_ALL && protect_complement));
		secure_ok = (bit_cnt_r == `BITS_ADDR) && (addr_r[23:16] == `SEC_HI_ZERO)
			&& (addr_r[11:10] == `SEC_MID_ZERO)
			&& ((addr_r[15:12] == `SEC_SEL_0 && !secure_area_lock_0)
			|| (addr_r[15:12] == `SEC_SEL_1 && !secure_area_lock_1));
	end

	// choose kind, length and aligned base; latch must already be set
	always_comb
	begin
		go = 1'b0;
		kind = flash_pkg::ER_32K;
		go_cycles = 32'(ERASE_32K_CYC);
		go_base = addr_r & `ALIGN_32K;
		case (opcode_r)
			`OP_ERASE_32K:
			begin
				go = block_ok;
			end
			`OP_ERASE_64K:
			begin
				go = block_ok;
				kind = flash_pkg::ER_64K;
				go_cycles = 32'(ERASE_64K_CYC);
				go_base = addr_r & `ALIGN_64K;
			end
			`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
			begin
				go = chip_ok;
				kind = flash_pkg::ER_CHIP;
				go_cycles = 32'(CHIP_ERASE_CYC);
				go_base = 24'h000000;
			end
			`OP_SECURE_ERASE:
			begin
				go = secure_ok;
				kind = flash_pkg::ER_SECURE;
				go_cycles = 32'(SECTOR_ERASE_CYC);
				go_base = {addr_r[23:10], 10'h000};
			end
			default:
			begin
				go = 1'b0;
			end
		endcase
		go = go && cs_rise && write_latch && !busy;
	end

	// self-timed cycle; its busy flop is one progress flag source, beside go and other_cycle_busy
	erase_timer #(
		.W(32)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(go),
		.cycles(go_cycles),
		.busy_r(timer_busy),
		.done_r(erase_done_r)
	);

	// progress flag follows the cycle and any other internal cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			progress_flag_r <= 1'b0;
		else
			progress_flag_r <= go || busy;
	end

	// erase hand-off: one-cycle go and latch clear, held kind and base
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			erase_go_r <= 1'b0;
			write_latch_clr_r <= 1'b0;
			erase_kind_r <= flash_pkg::ER_32K;
			erase_base_r <= 24'h000000;
		end
		else
		begin
			erase_go_r <= go;
			write_latch_clr_r <= go;
			if (go)
			begin
				erase_kind_r <= kind;
				erase_base_r <= go_base;
			end
		end
	end

	// frame decoder: inputs taken on sclk rise, counts kept to the select rise
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= flash_pkg::ST_IDLE;
			bit_cnt_r <= 6'h00;
			in_sr_r <= 32'h00000000;
			opcode_r <= 8'h00;
			addr_r <= 24'h000000;
		end
		else if (cs_sync_r[1])
		begin
			// deselected: read ends, back to standby
			state_r <= flash_pkg::ST_IDLE;
		end
		else if (cs_fall)
		begin
			state_r <= flash_pkg::ST_CMD;
			bit_cnt_r <= 6'h00;
			opcode_r <= 8'h00;
		end
		else if (sclk_rise)
		begin
			in_sr_r <= in_nxt;
			bit_cnt_r <= cnt_nxt;
			case (state_r)
				flash_pkg::ST_CMD:
				begin
					if (cnt_nxt == `BITS_OPCODE)
					begin
						opcode_r <= in_nxt[7:0];
						if (busy)
							state_r <= flash_pkg::ST_SKIP;
						else if (in_nxt[7:0] == `OP_IDENT_24)
							state_r <= flash_pkg::ST_OUT;
						else if (in_nxt[7:0] == `OP_ERASE_32K
							|| in_nxt[7:0] == `OP_ERASE_64K
							|| in_nxt[7:0] == `OP_SECURE_ERASE
							|| in_nxt[7:0] == `OP_MAKER_PART
							|| in_nxt[7:0] == `OP_UNIQUE_ID)
							state_r <= flash_pkg::ST_ADDR;
						else
							state_r <= flash_pkg::ST_SKIP; // chip erase or foreign
					end
				end
				flash_pkg::ST_ADDR:
				begin
					if (cnt_nxt == `BITS_ADDR)
					begin
						addr_r <= in_nxt[23:0];
						if (opcode_r == `OP_MAKER_PART)
							state_r <= flash_pkg::ST_OUT;
						else if (opcode_r != `OP_UNIQUE_ID)
							state_r <= flash_pkg::ST_SKIP; // erase waits for select rise
					end
					else if (cnt_nxt == `BITS_UID_LEAD)
					begin
						state_r <= flash_pkg::ST_OUT;
					end
				end
				default:
				begin
					state_r <= state_r; // output and skip just count bits
				end
			endcase
		end
	end

	// output shifter: loaded as the read begins, shifted on each sclk fall
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_sr_r <= 128'h0;
			so_out_r <= 1'b0;
			so_oe_n_r <= 1'b1;
		end
		else if (cs_sync_r[1])
		begin
			so_oe_n_r <= 1'b1;
		end
		else if (sclk_rise && state_r == flash_pkg::ST_CMD && cnt_nxt == `BITS_OPCODE)
		begin
			out_sr_r <= {MAKER_CODE, MEM_TYPE, CAPACITY, 104'h0};
		end
		else if (sclk_rise && state_r == flash_pkg::ST_ADDR && cnt_nxt == `BITS_ADDR)
		begin
			// pair repeats eight times so a read of up to 128 bits keeps cycling through both codes
			out_sr_r <= {8{MAKER_CODE, PART_CODE}};
		end
		else if (sclk_rise && state_r == flash_pkg::ST_ADDR && cnt_nxt == `BITS_UID_LEAD)
		begin
			out_sr_r <= UNIQUE_ID;
		end
		else if (sclk_fall && state_r == flash_pkg::ST_OUT)
		begin
			so_out_r <= out_sr_r[127];
			out_sr_r <= {out_sr_r[126:0], 1'b0};
			so_oe_n_r <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_DESELECT_RELEASES: assert property (cs_sync_r[1] |=> so_oe_n_r)
		else $error("output still driven after deselect");
	AST_GO_RAISES_FLAG: assert property (go |=> progress_flag_r ##1 progress_flag_r)
		else $error("progress flag not raised by erase start");
	AST_LATCH_CLEARED: assert property (go |=> write_latch_clr_r && erase_go_r)
		else $error("write latch not cleared at erase start");
	AST_BUSY_SKIPS_ID: assert property (sclk_rise && state_r == flash_pkg::ST_CMD
		&& cnt_nxt == `BITS_OPCODE && busy && !cs_sync_r[1]
		|=> state_r == flash_pkg::ST_SKIP)
		else $error("id read decoded while busy");
	AST_ALIGN_32K: assert property (go && kind == flash_pkg::ER_32K
		|=> erase_base_r[14:0] == 15'h0000)
		else $error("32K base not aligned");
	AST_ALIGN_64K: assert property (go && kind == flash_pkg::ER_64K
		|=> erase_base_r[15:0] == 16'h0000)
		else $error("64K base not aligned");
	AST_CHIP_EIGHT_BITS: assert property (go && kind == flash_pkg::ER_CHIP
		|-> bit_cnt_r == `BITS_OPCODE && chip_ok)
		else $error("chip erase started off the opcode boundary");
	AST_BLOCK_32_BITS: assert property (go && (kind == flash_pkg::ER_32K
		|| kind == flash_pkg::ER_64K) |-> $past(bit_cnt_r) == `BITS_ADDR)
		else $error("block erase started off the address boundary");
	AST_SECURE_LOCK: assert property (go && kind == flash_pkg::ER_SECURE
		|-> !(addr_r[12] ? secure_area_lock_1 : secure_area_lock_0))
		else $error("locked secure register erased");
	AST_NO_START_BUSY: assert property (busy |-> !go)
		else $error("erase started during a running cycle");
endmodule // flash_cmd_seq

// ---- tb/spi_host_model.sv ----
// spi host model driving select, serial clock and data into the sequencer
module spi_host_model (
	// system clock the host paces itself on
	input wire logic clk,
	// link pins toward the device
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire logic so_out_r,
	input wire logic so_oe_n_r
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: deselected, clock parked low, data parked
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end

	// one frame, 80 ns serial clock; sclk only toggles while selected
	// no power-down command is ever sent, so id reads are answered whenever no internal cycle runs
	task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
		output logic [127:0] rx);
		rx = '0;
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < ntx + nrx; i++)
		begin
			// bits go out msb first, set up during the low half
			if (i < ntx)
				si <= tx[63 - i];
			repeat (5) @(posedge clk);
			sclk <= 1'b1;
			// output bits changed on the last fall, so they are settled here
			if (i >= ntx)
				rx = {rx[126:0], so_out_r};
			repeat (5) @(posedge clk);
			sclk <= 1'b0;
		end
		// select rises right after the last bit
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		// released line must not keep showing the last bit
		si <= ~si;
		repeat (6) @(posedge clk);
	endtask
endmodule // spi_host_model

// ---- tb/tb_top.sv ----
// self-checking bench for the erase and identification sequencer
`include "flash_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// shortened erase lengths keep the run brief
	localparam int C32 = 600;
	localparam int C64 = 800;
	localparam int CCE = 1000;
	localparam int CSE = 500;
	// identity values, arbitrary
	localparam logic [7:0] MK = 8'h3C;
	localparam logic [7:0] PT = 8'h5A;
	localparam logic [7:0] MT = 8'h21;
	localparam logic [7:0] CP = 8'h14;
	localparam logic [127:0] UID = 128'hFEDCBA98765432100011223344556677;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, sclk, si, so_out_r, so_oe_n_r;
	logic write_latch = 1'b0;
	logic other_cycle_busy = 1'b0; // raised once to stand in for a program cycle
	logic [4:0] protect_bits = 5'h00;
	logic protect_complement = 1'b0;
	logic secure_area_lock_0 = 1'b0;
	logic secure_area_lock_1 = 1'b0;
	logic progress_flag_r, write_latch_clr_r, erase_go_r, erase_done_r;
	flash_pkg::erase_kind_t erase_kind_r, kind_s;
	logic [23:0] erase_base_r, base_s;
	logic clr_s;
	int bad_count = 0;
	int n_tests = 0;
	int go_cnt = 0;
	int done_cnt = 0;
	int since_go = 0;
	int len_s = 0;
	int oe_low = 0;

	flash_cmd_seq #(.MAKER_CODE(MK), .PART_CODE(PT), .MEM_TYPE(MT), .CAPACITY(CP),
		.UNIQUE_ID(UID), .ERASE_32K_CYC(C32), .ERASE_64K_CYC(C64),
		.CHIP_ERASE_CYC(CCE), .SECTOR_ERASE_CYC(CSE)) flash_cmd_seq_i (
		.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .si(si),
		.so_out_r(so_out_r), .so_oe_n_r(so_oe_n_r), .write_latch(write_latch),
		.other_cycle_busy(other_cycle_busy), .protect_bits(protect_bits),
		.protect_complement(protect_complement),
		.secure_area_lock_0(secure_area_lock_0), .secure_area_lock_1(secure_area_lock_1),
		.progress_flag_r(progress_flag_r), .write_latch_clr_r(write_latch_clr_r),
		.erase_go_r(erase_go_r), .erase_kind_r(erase_kind_r),
		.erase_base_r(erase_base_r), .erase_done_r(erase_done_r));

	spi_host_model spi_host_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
		.so_out_r(so_out_r), .so_oe_n_r(so_oe_n_r));

	// 125 MHz system clock
	initial
	begin
		forever #4 clk = ~clk;
	end

	// capture each erase start and its length, since the pulses last one cycle
	always @(posedge clk)
	begin
		if (erase_go_r === 1'b1)
		begin
			go_cnt <= go_cnt + 1;
			kind_s <= erase_kind_r;
			base_s <= erase_base_r;
			clr_s <= write_latch_clr_r;
			since_go <= 0;
		end
		else
			since_go <= since_go + 1;
		if (erase_done_r === 1'b1)
		begin
			len_s <= since_go;
			done_cnt <= done_cnt + 1;
		end
		if (so_oe_n_r === 1'b0)
			oe_low <= oe_low + 1;
	end

	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one erase frame; when accepted, optionally try an id read mid-cycle
	task automatic run_erase(input logic [31:0] oa, input int ntx, input bit go,
		input flash_pkg::erase_kind_t k, input logic [23:0] base, input bit cb,
		input int cyc, input bit ask_id);
		logic [127:0] rx;
		int oe0;
		go_cnt = 0;
		done_cnt = 0;
		spi_host_model_i.frame({oa, 32'h0}, ntx, 0, rx);
		repeat (12) @(posedge clk);
		check("go", go_cnt, go);
		check("flag", progress_flag_r, go);
		if (go)
		begin
			check("kind", kind_s, k);
			if (cb)
				check("base", base_s, base);
			check("clr", clr_s, 1'b1);
			if (ask_id)
			begin
				oe0 = oe_low;
				spi_host_model_i.frame({`OP_IDENT_24, 56'h0}, 8, 24, rx);
				check("busy_oe", oe_low, oe0);
			end
			for (int n = 0; n < cyc + 100 && done_cnt == 0; n++)
				@(posedge clk);
			check("len", (len_s >= cyc - 2 && len_s <= cyc + 2), 1'b1);
			repeat (3) @(posedge clk);
			check("flag_end", progress_flag_r, 1'b0);
			check("done", done_cnt, 1);
		end
	endtask

	// identification reads, including one cut short by select
	task automatic t_ids();
		logic [127:0] rx;
		int oe0;
		// a program cycle elsewhere in the device also blocks the id read
		other_cycle_busy <= 1'b1;
		oe0 = oe_low;
		spi_host_model_i.frame({`OP_IDENT_24, 56'h0}, 8, 8, rx);
		check("prog_busy_oe", oe_low, oe0);
		check("prog_busy_flag", progress_flag_r, 1'b1);
		other_cycle_busy <= 1'b0;
		spi_host_model_i.frame({`OP_IDENT_24, 56'h0}, 8, 4, rx);
		check("ident_cut", rx[3:0], MK[7:4]);
		check("oe_off", so_oe_n_r, 1'b1);
		spi_host_model_i.frame({`OP_IDENT_24, 56'h0}, 8, 32, rx);
		check("ident", rx[31:0], {MK, MT, CP, 8'h00});
		spi_host_model_i.frame({`OP_MAKER_PART, 56'h0}, 32, 16, rx);
		check("maker_part", rx[15:0], {MK, PT});
		spi_host_model_i.frame({`OP_UNIQUE_ID, 56'h0}, 40, 128, rx);
		check("unique", rx, UID);
	endtask

	// block erases: alignment, protection, bit count, latch
	task automatic t_block();
		write_latch <= 1'b1;
		protect_bits <= 5'h01;
		run_erase({`OP_ERASE_32K, 24'h01ABCD}, 32, 1, flash_pkg::ER_32K, 24'h018000, 1, C32, 0);
		run_erase({`OP_ERASE_64K, 24'h01ABCD}, 32, 1, flash_pkg::ER_64K, 24'h010000, 1, C64, 1);
		run_erase({`OP_ERASE_32K, 24'h07F000}, 32, 0, flash_pkg::ER_32K, 24'h0, 0, C32, 0);
		run_erase({`OP_ERASE_64K, 24'h070000}, 32, 0, flash_pkg::ER_64K, 24'h0, 0, C64, 0);
		// bottom-anchored protection covers block 0 instead
		protect_bits <= 5'h09;
		run_erase({`OP_ERASE_64K, 24'h00FFFF}, 32, 0, flash_pkg::ER_64K, 24'h0, 0, C64, 0);
		run_erase({`OP_ERASE_32K, 24'h01ABCD}, 40, 0, flash_pkg::ER_32K, 24'h0, 0, C32, 0);
		run_erase({`OP_ERASE_64K, 24'h01ABCD}, 31, 0, flash_pkg::ER_64K, 24'h0, 0, C64, 0);
		write_latch <= 1'b0;
		run_erase({`OP_ERASE_32K, 24'h01ABCD}, 32, 0, flash_pkg::ER_32K, 24'h0, 0, C32, 0);
	endtask

	// chip erase: both opcodes, bit count, protection combinations
	task automatic t_chip();
		write_latch <= 1'b1;
		protect_bits <= 5'h00;
		run_erase({`OP_CHIP_ERASE_A, 24'h0}, 8, 1, flash_pkg::ER_CHIP, 24'h0, 0, CCE, 0);
		run_erase({`OP_CHIP_ERASE_B, 24'h0}, 8, 1, flash_pkg::ER_CHIP, 24'h0, 0, CCE, 0);
		run_erase({`OP_CHIP_ERASE_A, 24'h0}, 16, 0, flash_pkg::ER_CHIP, 24'h0, 0, CCE, 0);
		protect_bits <= 5'h01;
		run_erase({`OP_CHIP_ERASE_B, 24'h0}, 8, 0, flash_pkg::ER_CHIP, 24'h0, 0, CCE, 0);
		protect_bits <= 5'h00;
		protect_complement <= 1'b1;
		run_erase({`OP_CHIP_ERASE_A, 24'h0}, 8, 0, flash_pkg::ER_CHIP, 24'h0, 0, CCE, 0);
		protect_bits <= 5'h07;
		run_erase({`OP_CHIP_ERASE_A, 24'h0}, 8, 1, flash_pkg::ER_CHIP, 24'h0, 0, CCE, 0);
	endtask

	// secure register erase: selection, address fields, the area 1 lock
	task automatic t_secure();
		logic [23:0] bad [3] = '{24'h001400, 24'h002000, 24'h010000};
		protect_bits <= 5'h00;
		protect_complement <= 1'b0;
		secure_area_lock_1 <= 1'b1;
		run_erase({`OP_SECURE_ERASE, 24'h0003FF}, 32, 1, flash_pkg::ER_SECURE, 24'h0, 0, CSE, 0);
		run_erase({`OP_SECURE_ERASE, 24'h0013FF}, 32, 0, flash_pkg::ER_SECURE, 24'h0, 0, CSE, 0);
		secure_area_lock_1 <= 1'b0;
		run_erase({`OP_SECURE_ERASE, 24'h0013FF}, 32, 1, flash_pkg::ER_SECURE, 24'h0, 0, CSE, 0);
		foreach (bad[i])
			run_erase({`OP_SECURE_ERASE, bad[i]}, 32, 0, flash_pkg::ER_SECURE, 24'h0, 0, CSE, 0);
	endtask

	// main sequence: reset for 16 cycles, then the scenarios
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_ids();
		t_block();
		t_chip();
		t_secure();
		give_verdict();
	end

	// watchdog well beyond the expected run of about 14000 cycles
	initial
	begin
		#400000;
		bad_count++;
		give_verdict();
	end
endmodule // tb_top
